/* File: logic/utpg_pkg.sv */
// Constants for the user test pattern generator: register map, fields, resets.
// Assumes an Avalon-MM slave with byte addresses, one 32-bit word per register.
package utpg_pkg;
   // Printed offsets are not all multiples of four: they are indexes, byte address = 4 * index
   localparam logic [9:0]  UTPG_IDX_SAMPLE0   = 10'h180;
   localparam logic [9:0]  UTPG_IDX_SAMPLE4   = 10'h188;
   localparam logic [9:0]  UTPG_IDX_SAMPLE5   = 10'h18A;
   localparam logic [9:0]  UTPG_IDX_SAMPLE6   = 10'h18C;
   localparam logic [9:0]  UTPG_IDX_SAMPLE7   = 10'h18E;
   localparam logic [9:0]  UTPG_IDX_CTRL      = 10'h190;
   localparam logic [9:0]  UTPG_IDX_ENABLE    = 10'h200;
   localparam logic [9:0]  UTPG_IDX_SELECT    = 10'h1A0;
   localparam int          UTPG_NUM_SAMPLES   = 8;
   localparam int          UTPG_SAMPLE_W      = 12;
   localparam int          UTPG_CTRL_W        = 5;
   localparam int          UTPG_BUS_A_BIT     = 8;
   localparam int          UTPG_BUS_B_BIT     = 9;
   localparam int          UTPG_BUS_C_BIT     = 10;
   localparam int          UTPG_BUS_D_BIT     = 11;
   localparam int          UTPG_CTRL_INV_A    = 0;
   localparam int          UTPG_CTRL_INV_B    = 1;
   localparam int          UTPG_CTRL_INV_C    = 2;
   localparam int          UTPG_CTRL_INV_D    = 3;
   localparam int          UTPG_CTRL_PRESET   = 4;
   localparam logic [4:0]  UTPG_CTRL_RESET    = 5'h1E;
   localparam logic [11:0] UTPG_ZEROS         = 12'h000;
   localparam logic [11:0] UTPG_ONES          = 12'hFFF;
   // Reset values for samples 0..7
   localparam logic [95:0] UTPG_SAMPLE_RESET  =
      {UTPG_ONES, UTPG_ZEROS, UTPG_ONES, UTPG_ZEROS,
       UTPG_ONES, UTPG_ZEROS, UTPG_ONES, UTPG_ZEROS};
   // Fixed preset sequence, sample 7 in the top slot
   localparam logic [95:0] UTPG_PRESET_SEQ    =
      {UTPG_ONES, UTPG_ONES, UTPG_ONES, UTPG_ZEROS,
       UTPG_ZEROS, UTPG_ZEROS, UTPG_ONES, UTPG_ZEROS};
   localparam logic        UTPG_ENABLE_RESET  = 1'b1;
   localparam logic        UTPG_SELECT_RESET  = 1'b0;
endpackage : utpg_pkg

/* File: logic/utpg_link.sv */
// Link-side pattern player, running on the link clock.
// Assumes config words are held stable by the bus-side registers while the enable is high.
`timescale 1ns/1ps
`default_nettype none
module utpg_link
   import utpg_pkg::*;
(
   input  wire logic        link_clk,
   input  wire logic        link_rstn,
   input  wire logic        enable_async,
   input  wire logic [95:0] pattern_cfg,
   input  wire logic [3:0]  flip_cfg,
   output logic [11:0]      bus_a_q,
   output logic [11:0]      bus_b_q,
   output logic [11:0]      bus_c_q,
   output logic [11:0]      bus_d_q,
   output logic             active_q
);
   logic        en_meta_q;
   logic        en_sync_q;
   logic [2:0]  slot_q;
   logic [2:0]  slot_d;
   logic [11:0] bus_d  [4];
   logic [11:0] bus_qv [4];
   logic [11:0] cur;
   logic        active_d;
   int          flip_bit [4];

   assign flip_bit[0] = UTPG_BUS_A_BIT;
   assign flip_bit[1] = UTPG_BUS_B_BIT;
   assign flip_bit[2] = UTPG_BUS_C_BIT;
   assign flip_bit[3] = UTPG_BUS_D_BIT;

   always_comb begin
      cur      = pattern_cfg[slot_q*UTPG_SAMPLE_W +: UTPG_SAMPLE_W];
      active_d = en_sync_q;
      slot_d   = en_sync_q ? slot_q + 3'd1 : 3'd0;
      for (int b = 0; b < 4; b++) begin
         bus_d[b] = UTPG_ZEROS; // Outputs parked low while disabled
         if (en_sync_q) begin
            bus_d[b] = cur;
            bus_d[b][flip_bit[b]] = cur[flip_bit[b]] ^ flip_cfg[b];
         end
      end
   end

   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         en_meta_q <= 1'b0;
         en_sync_q <= 1'b0;
         slot_q    <= 3'd0;
         active_q  <= 1'b0;
         for (int b = 0; b < 4; b++) bus_qv[b] <= UTPG_ZEROS;
      end else begin
         en_meta_q <= enable_async;
         en_sync_q <= en_meta_q;
         slot_q    <= slot_d;
         active_q  <= active_d;
         for (int b = 0; b < 4; b++) bus_qv[b] <= bus_d[b];
      end
   end

   assign bus_a_q = bus_qv[0];
   assign bus_b_q = bus_qv[1];
   assign bus_c_q = bus_qv[2];
   assign bus_d_q = bus_qv[3];

   AST_IDLE_ZERO: assert property (@(posedge link_clk) disable iff (!link_rstn)
      !en_sync_q |=> (bus_a_q == 12'h000 && !active_q))
      else $error("bus not parked while disabled");
   AST_SLOT_STEP: assert property (@(posedge link_clk) disable iff (!link_rstn)
      en_sync_q |=> slot_q == $past(slot_q) + 3'd1)
      else $error("slot did not advance");
   AST_FLIP_D: assert property (@(posedge link_clk) disable iff (!link_rstn)
      en_sync_q |=> bus_d_q[11] == ($past(cur[11]) ^ $past(flip_cfg[3])))
      else $error("bus D msb flip wrong");
   AST_FLIP_C: assert property (@(posedge link_clk) disable iff (!link_rstn)
      en_sync_q |=> bus_c_q[10] == ($past(cur[10]) ^ $past(flip_cfg[2])))
      else $error("bus C bit 10 flip wrong");
   AST_FLIP_B: assert property (@(posedge link_clk) disable iff (!link_rstn)
      en_sync_q |=> bus_b_q[9] == ($past(cur[9]) ^ $past(flip_cfg[1])))
      else $error("bus B bit 9 flip wrong");
   AST_FLIP_A: assert property (@(posedge link_clk) disable iff (!link_rstn)
      en_sync_q |=> bus_a_q[8] == ($past(cur[8]) ^ $past(flip_cfg[0])))
      else $error("bus A bit 8 flip wrong");
   AST_OTHER_BITS: assert property (@(posedge link_clk) disable iff (!link_rstn)
      en_sync_q |=> bus_a_q[11:9] == $past(cur[11:9]) && bus_d_q[10:0] == $past(cur[10:0]))
      else $error("unflipped bits changed");
endmodule : utpg_link
`default_nettype wire

/* File: logic/utpg_top.sv */
// Top of the user test pattern generator: Avalon-MM register slave and link player.
// Assumes a 100 MHz bus clock and an unrelated link clock from the serializer.
`timescale 1ns/1ps
`default_nettype none
module utpg_top
   import utpg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        link_clk,
   input  wire logic [11:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic [1:0]       avs_response,
   output logic [11:0]      bus_a_out,
   output logic [11:0]      bus_b_out,
   output logic [11:0]      bus_c_out,
   output logic [11:0]      bus_d_out,
   output logic             link_active
);
   logic        rst_meta_q;
   logic        rst_sync_q;
   logic        lrst_meta_q;
   logic        lrst_sync_q;
   logic [15:0] sample_q [UTPG_NUM_SAMPLES];
   logic [15:0] sample_d [UTPG_NUM_SAMPLES];
   logic [7:0]  ctrl_q;
   logic [7:0]  ctrl_d;
   logic        enable_q;
   logic        enable_d;
   logic        select_q;
   logic        select_d;
   logic        ack_q;
   logic        ack_d;
   // Waitrequest gets its own flop so the pin comes straight from a register
   logic        waitreq_q;
   logic        waitreq_d;
   logic [95:0] user_image;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [1:0]  resp_q;
   logic [1:0]  resp_d;
   logic [95:0] pattern_q;
   logic [95:0] pattern_d;
   logic [3:0]  flip_q;
   logic [3:0]  flip_d;
   logic        play_q;
   logic        play_d;
   logic [9:0]  idx;
   logic        aligned;
   logic        req;
   logic [15:0] wmask;

   // Reset release through two flops per domain
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         lrst_meta_q <= 1'b0;
         lrst_sync_q <= 1'b0;
      end else begin
         lrst_meta_q <= 1'b1;
         lrst_sync_q <= lrst_meta_q;
      end
   end

   assign idx     = avs_address[11:2];
   assign aligned = avs_address[1:0] == 2'b00;
   assign req     = (avs_read || avs_write) && !ack_q;
   assign wmask   = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // Register file and bus answer: one wait cycle, then ack
   always_comb begin
      for (int i = 0; i < UTPG_NUM_SAMPLES; i++) sample_d[i] = sample_q[i];
      ctrl_d   = ctrl_q;
      enable_d = enable_q;
      select_d = select_q;
      ack_d    = req;
      waitreq_d = !req;
      rdata_d  = rdata_q;
      resp_d   = 2'b00;
      if (req) begin
         rdata_d = 32'h0000_0000;
         if (!aligned) begin
            resp_d = 2'b11;
         end else if (idx >= UTPG_IDX_SAMPLE0 && idx <= UTPG_IDX_SAMPLE7 && !idx[0]) begin
            // Even indexes 180..18E hold samples 0..7
            rdata_d = {16'h0000, sample_q[idx[3:1]]};
            if (avs_write) begin
               // Reserved bits 15-12 kept as storage
               sample_d[idx[3:1]] = (sample_q[idx[3:1]] & ~wmask) | (avs_writedata[15:0] & wmask);
            end
         end else if (idx == UTPG_IDX_CTRL) begin
            rdata_d = {24'h000000, ctrl_q};
            if (avs_write && avs_byteenable[0]) begin
               ctrl_d = avs_writedata[7:0];
            end
         end else if (idx == UTPG_IDX_ENABLE) begin
            rdata_d = {31'h0, enable_q};
            if (avs_write && avs_byteenable[0]) begin
               enable_d = avs_writedata[0];
            end
         end else if (idx == UTPG_IDX_SELECT) begin
            rdata_d = {31'h0, select_q};
            if (avs_write && avs_byteenable[0]) begin
               select_d = avs_writedata[0];
            end
         end else begin
            resp_d = 2'b11;
         end
      end
   end

   // One slice per sample
   for (genvar g = 0; g < UTPG_NUM_SAMPLES; g++) begin : g_image
      assign user_image[g*UTPG_SAMPLE_W +: UTPG_SAMPLE_W] = sample_q[g][11:0];
   end

   // Pattern image handed to link domain; held when enabled, reloaded only when disabled
   always_comb begin
      pattern_d = pattern_q;
      flip_d    = flip_q;
      play_d    = enable_q && select_q;
      if (!enable_q) begin
         pattern_d = user_image;
         if (ctrl_q[UTPG_CTRL_PRESET]) begin
            pattern_d = UTPG_PRESET_SEQ;
         end
         flip_d = ctrl_q[3:0];
      end
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         for (int i = 0; i < UTPG_NUM_SAMPLES; i++) begin
            sample_q[i] <= {4'h0, UTPG_SAMPLE_RESET[i*UTPG_SAMPLE_W +: UTPG_SAMPLE_W]};
         end
         ctrl_q    <= {3'h0, UTPG_CTRL_RESET};
         enable_q  <= UTPG_ENABLE_RESET;
         select_q  <= UTPG_SELECT_RESET;
         ack_q     <= 1'b0;
         waitreq_q <= 1'b1;
         rdata_q   <= 32'h0000_0000;
         resp_q    <= 2'b00;
         pattern_q <= UTPG_PRESET_SEQ;
         flip_q    <= UTPG_CTRL_RESET[3:0];
         play_q    <= 1'b0;
      end else begin
         for (int i = 0; i < UTPG_NUM_SAMPLES; i++) sample_q[i] <= sample_d[i];
         ctrl_q    <= ctrl_d;
         enable_q  <= enable_d;
         select_q  <= select_d;
         ack_q     <= ack_d;
         waitreq_q <= waitreq_d;
         rdata_q   <= rdata_d;
         resp_q    <= resp_d;
         pattern_q <= pattern_d;
         flip_q    <= flip_d;
         play_q    <= play_d;
      end
   end

   // Waitrequest is a flop: high except for the single ack cycle
   assign avs_waitrequest = waitreq_q;
   assign avs_readdata    = rdata_q;
   assign avs_response    = resp_q;

   // Config words are quasi-static: only sampled while play level is high
   // and they never change while enable is high, so a level sync suffices.
   utpg_link u_link (
      .link_clk     (link_clk),
      .link_rstn    (lrst_sync_q),
      .enable_async (play_q),
      .pattern_cfg  (pattern_q),
      .flip_cfg     (flip_q),
      .bus_a_q      (bus_a_out),
      .bus_b_q      (bus_b_out),
      .bus_c_q      (bus_c_out),
      .bus_d_q      (bus_d_out),
      .active_q     (link_active)
   );

   AST_CTRL_RESET: assert property (@(posedge clk) $rose(rst_sync_q) |-> ctrl_q == 8'h1E)
      else $error("control reset value wrong");
   AST_SAMPLE_RESET: assert property (@(posedge clk)
      $rose(rst_sync_q) |-> sample_q[4] == 16'h0000 && sample_q[5] == 16'h0FFF
         && sample_q[6] == 16'h0000 && sample_q[7] == 16'h0FFF)
      else $error("sample reset values wrong");
   AST_PRESET_IMAGE: assert property (@(posedge clk) disable iff (!rst_sync_q)
      (!enable_q && ctrl_q[4]) |=> pattern_q == 96'hFFF_FFF_FFF_000_000_000_FFF_000)
      else $error("preset image wrong");
   AST_FLIP_IMAGE: assert property (@(posedge clk) disable iff (!rst_sync_q)
      !enable_q |=> flip_q == $past(ctrl_q[3:0]))
      else $error("flip image not copied");
   AST_PLAY_NEEDS_SEL: assert property (@(posedge clk) disable iff (!rst_sync_q)
      !select_q |=> !play_q)
      else $error("pattern played without selection");
   AST_ONE_WAIT: assert property (@(posedge clk) disable iff (!rst_sync_q)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer timing wrong");

   // Idle bus never answers on its own
   AST_WAIT_IDLE: assert property (@(posedge clk) disable iff (!rst_sync_q)
      !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
      else $error("answer without request");
   AST_RESP_UNALIGNED: assert property (@(posedge clk) disable iff (!rst_sync_q)
      req && !aligned |=> avs_response == 2'b11)
      else $error("unaligned access not refused");
   AST_READ_SAMPLE4: assert property (@(posedge clk) disable iff (!rst_sync_q)
      req && !avs_write && aligned && idx == UTPG_IDX_SAMPLE4
         |=> avs_response == 2'b00 && avs_readdata == {16'h0000, $past(sample_q[4])})
      else $error("sample four read wrong");

   // Full-lane writes land whole in the addressed sample
   AST_WRITE_SAMPLE4: assert property (@(posedge clk) disable iff (!rst_sync_q)
      req && avs_write && aligned && idx == UTPG_IDX_SAMPLE4 && avs_byteenable[1:0] == 2'b11
         |=> sample_q[4] == $past(avs_writedata[15:0]))
      else $error("sample four write lost");
   AST_WRITE_SAMPLE5: assert property (@(posedge clk) disable iff (!rst_sync_q)
      req && avs_write && aligned && idx == UTPG_IDX_SAMPLE5 && avs_byteenable[1:0] == 2'b11
         |=> sample_q[5] == $past(avs_writedata[15:0]))
      else $error("sample five write lost");
   AST_WRITE_SAMPLE6: assert property (@(posedge clk) disable iff (!rst_sync_q)
      req && avs_write && aligned && idx == UTPG_IDX_SAMPLE6 && avs_byteenable[1:0] == 2'b11
         |=> sample_q[6] == $past(avs_writedata[15:0]))
      else $error("sample six write lost");
   AST_WRITE_SAMPLE7: assert property (@(posedge clk) disable iff (!rst_sync_q)
      req && avs_write && aligned && idx == UTPG_IDX_SAMPLE7 && avs_byteenable[1:0] == 2'b11
         |=> sample_q[7] == $past(avs_writedata[15:0]))
      else $error("sample seven write lost");
   AST_WRITE_CTRL: assert property (@(posedge clk) disable iff (!rst_sync_q)
      req && avs_write && aligned && idx == UTPG_IDX_CTRL && avs_byteenable[0]
         |=> ctrl_q == $past(avs_writedata[7:0]))
      else $error("control write lost");

   // Link reads the image without a handshake, so it must not move while enabled
   AST_IMAGE_HELD: assert property (@(posedge clk) disable iff (!rst_sync_q)
      enable_q |=> $stable(pattern_q) && $stable(flip_q))
      else $error("image changed while enabled");
   AST_USER_IMAGE: assert property (@(posedge clk) disable iff (!rst_sync_q)
      !enable_q && !ctrl_q[4] |=> pattern_q[47:36] == $past(sample_q[3][11:0]))
      else $error("user image slice wrong");
   AST_PLAY_ON: assert property (@(posedge clk) disable iff (!rst_sync_q)
      enable_q && select_q |=> play_q)
      else $error("play level not raised");
   AST_PLAY_OFF: assert property (@(posedge clk) disable iff (!rst_sync_q)
      !enable_q |=> !play_q)
      else $error("play level not dropped");
   AST_SELECT_RESET: assert property (@(posedge clk)
      $rose(rst_sync_q) |-> !select_q && enable_q)
      else $error("enable or chooser reset wrong");
endmodule : utpg_top
`default_nettype wire

/* File: test/utpg_rx_model.sv */
// Receiver model: grabs eight consecutive samples from each bus while the link plays.
// Assumes the first sample seen with link_active high is sample 0.
`timescale 1ns/1ps
`default_nettype none
module utpg_rx_model (
   input  wire logic        link_clk,
   input  wire logic        active,
   input  wire logic [11:0] bus_a,
   input  wire logic [11:0] bus_b,
   input  wire logic [11:0] bus_c,
   input  wire logic [11:0] bus_d,
   output logic [95:0]      cap_a,
   output logic [95:0]      cap_b,
   output logic [95:0]      cap_c,
   output logic [95:0]      cap_d,
   output logic             got
);
   int cnt = 0;
   initial got = 1'b0;
   // Rearms whenever the link stops, so each run is captured afresh
   always @(posedge link_clk) begin
      if (active !== 1'b1) begin
         cnt <= 0;
         got <= 1'b0;
      end else if (cnt < 8) begin
         cap_a[cnt*12 +: 12] <= bus_a;
         cap_b[cnt*12 +: 12] <= bus_b;
         cap_c[cnt*12 +: 12] <= bus_c;
         cap_d[cnt*12 +: 12] <= bus_d;
         cnt <= cnt + 1;
         got <= (cnt == 7);
      end
   end
endmodule : utpg_rx_model
`default_nettype wire

/* File: test/utpg_tb_top.sv */
// Testbench for the user test pattern generator: register tasks and playback checks.
// Assumes the receiver model in test/ and the design files under logic/.
`timescale 1ns/1ps
`default_nettype none
module user_test_pattern_generator_tb_top
   import utpg_pkg::*;
;
   localparam logic [95:0] PRESET = 96'hFFF_FFF_FFF_000_000_000_FFF_000;
   localparam logic [95:0] USER   = 96'hB3C_2A5_F01_789_CDE_456_9AB_123;
   logic        clk = 1'b0;
   logic        link_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [11:0] avs_address = 12'h000;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [1:0]  avs_response;
   logic [11:0] bus_a_out, bus_b_out, bus_c_out, bus_d_out;
   logic        link_active;
   logic [95:0] cap_a, cap_b, cap_c, cap_d;
   logic        got;
   logic [31:0] rd;
   logic [1:0]  rsp;
   int          failures = 0;
   int          compares = 0;

   always #5 clk = ~clk;
   initial begin
      #3;
      forever #15 link_clk = ~link_clk;
   end

   utpg_top utpg_top_inst (.clk(clk), .rstn(rstn), .link_clk(link_clk),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
      .bus_a_out(bus_a_out), .bus_b_out(bus_b_out), .bus_c_out(bus_c_out),
      .bus_d_out(bus_d_out), .link_active(link_active));

   utpg_rx_model utpg_rx_model_inst (.link_clk(link_clk), .active(link_active),
      .bus_a(bus_a_out), .bus_b(bus_b_out), .bus_c(bus_c_out), .bus_d(bus_d_out),
      .cap_a(cap_a), .cap_b(cap_b), .cap_c(cap_c), .cap_d(cap_d), .got(got));

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] seen);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Request held until waitrequest is sampled low; one idle edge before the next
   task automatic bus_op(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      int n;
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      rsp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         chk("waitrequest", 96'h0, 96'h1);
         report_and_stop();
      end
      @(posedge clk);
   endtask : bus_op

   task automatic rd_chk(input string what, input logic [9:0] idx, input logic [31:0] exp);
      bus_op(1'b0, idx, 32'h0000_0000);
      chk(what, {64'h0, exp}, {64'h0, rd});
   endtask : rd_chk

   function automatic logic [95:0] flip(input logic [95:0] s, input int b, input logic f);
      flip = s;
      for (int i = 0; i < 8; i++) begin
         flip[i*12 + b] = s[i*12 + b] ^ f;
      end
   endfunction : flip

   task automatic play(input logic [4:0] ctl);
      logic [95:0] s;
      int          n;
      s = ctl[4] ? PRESET : USER;
      bus_op(1'b1, UTPG_IDX_CTRL, {27'h0, ctl});
      bus_op(1'b1, UTPG_IDX_ENABLE, 32'h0000_0001);
      n = 0;
      while (got !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (n >= 300) begin
         chk("capture", 96'h1, 96'h0);
         report_and_stop();
      end
      chk("bus_a", flip(s, 8, ctl[0]), cap_a);
      chk("bus_b", flip(s, 9, ctl[1]), cap_b);
      chk("bus_c", flip(s, 10, ctl[2]), cap_c);
      chk("bus_d", flip(s, 11, ctl[3]), cap_d);
      bus_op(1'b1, UTPG_IDX_ENABLE, 32'h0000_0000);
      repeat (20) @(posedge clk);
      chk("parked", 96'h0, {47'h0, bus_a_out, bus_b_out, bus_c_out, bus_d_out, link_active});
   endtask : play

   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk("sample_four", UTPG_IDX_SAMPLE4, 32'h0000_0000);
      rd_chk("sample_five", UTPG_IDX_SAMPLE5, 32'h0000_0FFF);
      rd_chk("sample_six", UTPG_IDX_SAMPLE6, 32'h0000_0000);
      rd_chk("sample_seven", UTPG_IDX_SAMPLE7, 32'h0000_0FFF);
      rd_chk("pattern_control", UTPG_IDX_CTRL, 32'h0000_001E);
      chk("idle_active", 96'h0, {95'h0, link_active});
      rd_chk("unmapped", 10'h3FC, 32'h0000_0000);
      chk("unmapped_resp", 96'h3, {94'h0, rsp});
      bus_op(1'b1, UTPG_IDX_ENABLE, 32'h0000_0000);
      bus_op(1'b1, UTPG_IDX_SAMPLE4, 32'h0000_FA5C);
      rd_chk("sample_four_rw", UTPG_IDX_SAMPLE4, 32'h0000_FA5C);
      for (int i = 0; i < 8; i++) begin
         bus_op(1'b1, UTPG_IDX_SAMPLE0 + 10'(2 * i), {20'h0, USER[i*12 +: 12]});
      end
      bus_op(1'b1, UTPG_IDX_SELECT, 32'h0000_0001);
      play(5'h1E);
      play(5'h01);
      play(5'h1B);
      play(5'h06);
      report_and_stop();
   end
endmodule : user_test_pattern_generator_tb_top
`default_nettype wire
